// ==== src/ivp_vector_place.v ====
// interrupt vector placement with timed unlock and wishbone registers
//
// Local design decisions: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "ivp_defines.vh"

module ivp_vector_place (
  input  wire                     clock,
  input  wire                     rst_b,
  // classic wishbone slave
  input  wire                     wb_cyc_i,
  input  wire                     wb_stb_i,
  input  wire                     wb_we_i,
  input  wire [`IVP_ADDR_W-1:0]   wb_adr_i,
  input  wire [31:0]              wb_dat_i,
  input  wire [3:0]               wb_sel_i,
  output reg  [31:0]              wb_dat_o,
  output wire                     wb_ack_o,
  output wire                     wb_err_o,
  // fuse and lock settings
  input  wire [1:0]               bootSizeSelect,
  input  wire                     bootResetSelect,
  input  wire                     appSideLockBit,
  input  wire                     bootSideLockBit,
  // cpu side
  input  wire                     instrRetire,
  input  wire [`IVP_PC_W-1:0]     execPc,
  input  wire [4:0]               vectorNumber,
  input  wire                     globalIntEnable,
  output reg                      intAllow,
  output reg  [`IVP_PC_W-1:0]     tableBase,
  output reg  [`IVP_PC_W-1:0]     resetAddr,
  output reg  [`IVP_PC_W-1:0]     vectorAddr,
  output reg  [`IVP_PC_W-1:0]     storeProgReadyVector
);

  // sequence states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_OPEN = 3'b010;
  localparam [2:0] ST_TAIL = 3'b100;
  // control reset word, so the select bit can be picked out at its own width
  localparam [7:0] CTRL_RST = `IVP_CTRL_RESET;

  reg  [2:0]              state_reg;
  reg  [2:0]              state_next;
  reg  [`IVP_CNT_W-1:0]   count_reg;
  reg  [`IVP_CNT_W-1:0]   count_next;
  reg                     select_reg;
  reg                     select_next;
  reg                     unlock_reg;
  reg                     unlock_next;
  reg                     ack_reg;
  wire [`IVP_PC_W-1:0]    bootStart;
  wire [`IVP_PC_W-1:0]    baseWire;
  wire [`IVP_PC_W-1:0]    resetWire;
  wire                    reqNew;
  wire                    ctrlWrite;
  wire                    wrUnlock;
  wire                    wrSelect;
  wire                    inBoot;
  wire                    lockBlock;
  wire                    hold;
  wire                    mapped;

  // address decode used in three places
  function isMapped;
    input [`IVP_ADDR_W-1:0] a;
    begin
      isMapped = (a == `IVP_OFF_CTRL) || (a == `IVP_OFF_STATUS) || (a == `IVP_OFF_BASE);
    end
  endfunction

  ivp_boot_decode uDecode (
    .bootSizeSelect   (bootSizeSelect),
    .vectorBaseSelect (select_reg),
    .bootResetSelect  (bootResetSelect),
    .bootStart        (bootStart),
    .tableBase        (baseWire),
    .resetAddr        (resetWire)
  );

  // one answer per request; ack drops the cycle after
  assign reqNew    = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign mapped    = isMapped(wb_adr_i);
  assign wb_ack_o  = ack_reg & isMapped(wb_adr_i);
  assign wb_err_o  = ack_reg & ~isMapped(wb_adr_i);
  // byte lane 0 carries the whole 8-bit control register
  assign ctrlWrite = reqNew & wb_we_i & wb_sel_i[0] & (wb_adr_i == `IVP_OFF_CTRL);
  assign wrUnlock  = ctrlWrite & wb_dat_i[`IVP_BIT_UNLOCK];
  // a select write is any control write with unlock zero
  assign wrSelect  = ctrlWrite & ~wb_dat_i[`IVP_BIT_UNLOCK];

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= reqNew;
    end
  end

  // unlock sequence and hold-off
  always @* begin
    state_next  = state_reg;
    count_next  = count_reg;
    select_next = select_reg;
    unlock_next = unlock_reg;
    case (state_reg)
      ST_IDLE: begin
        if (wrUnlock) begin
          state_next  = ST_OPEN;
          count_next  = `IVP_WINDOW_CYCLES - 3'h1;
          unlock_next = 1'b1;
        end
        // select writes here are dropped
      end
      ST_OPEN: begin
        if (wrSelect) begin
          select_next = wb_dat_i[`IVP_BIT_SELECT];
          unlock_next = 1'b0;
          state_next  = ST_TAIL;
        end else if (wrUnlock) begin
          count_next = `IVP_WINDOW_CYCLES - 3'h1;
        end else if (count_reg == 3'h0) begin
          unlock_next = 1'b0;
          state_next  = ST_IDLE;
        end else begin
          count_next = count_reg - 3'h1;
        end
      end
      ST_TAIL: begin
        // hold until the next instruction completes
        if (instrRetire) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next  = ST_IDLE;
        unlock_next = 1'b0;
      end
    endcase
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg  <= ST_IDLE;
      count_reg  <= {`IVP_CNT_W{1'b0}};
      select_reg <= CTRL_RST[`IVP_BIT_SELECT];
      unlock_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      count_reg  <= count_next;
      select_reg <= select_next;
      unlock_reg <= unlock_next;
    end
  end

  // hold-off starts in the unlock write cycle itself
  assign hold = wrUnlock | (state_reg != ST_IDLE);

  // code region of the running instruction
  assign inBoot    = (execPc >= bootStart);
  assign lockBlock = (select_reg & appSideLockBit & ~inBoot)
                   | (~select_reg & bootSideLockBit & inBoot);

  // gating only: the global enable is read, never written
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      intAllow <= 1'b0;
    end else begin
      intAllow <= globalIntEnable & ~hold & ~lockBlock;
    end
  end

  // registered placement outputs; vectors are two words apart
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tableBase            <= `IVP_FLASH_START;
      resetAddr            <= `IVP_FLASH_START;
      vectorAddr           <= `IVP_FLASH_START;
      storeProgReadyVector <= `IVP_LAST_VEC_OFFSET;
    end else begin
      tableBase            <= baseWire;
      resetAddr            <= resetWire;
      vectorAddr           <= baseWire + {8'h00, vectorNumber, 1'b0};
      storeProgReadyVector <= baseWire + `IVP_LAST_VEC_OFFSET;
    end
  end

  // read data, captured with the request
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (reqNew && !wb_we_i && mapped) begin
      case (wb_adr_i)
        `IVP_OFF_CTRL:   wb_dat_o <= {30'h0, select_next, unlock_next};
        `IVP_OFF_STATUS: wb_dat_o <= {29'h0, (state_reg == ST_OPEN), lockBlock, hold};
        `IVP_OFF_BASE:   wb_dat_o <= {18'h0, baseWire};
        default:         wb_dat_o <= 32'h0000_0000;
      endcase
    end else if (reqNew) begin
      wb_dat_o <= 32'h0000_0000;
    end
  end

endmodule
`default_nettype wire

// ==== src/ivp_defines.vh ====
// constants for the interrupt vector placement block
`ifndef IVP_DEFINES_VH
`define IVP_DEFINES_VH

// register map (word index times four)
`define IVP_ADDR_W          4
`define IVP_OFF_CTRL        4'h0
`define IVP_OFF_STATUS      4'h4
`define IVP_OFF_BASE        4'h8

// core_control field layout
`define IVP_BIT_UNLOCK      0
`define IVP_BIT_SELECT      1
`define IVP_CTRL_RESET      8'h00

// status field layout
`define IVP_ST_HOLD         0
`define IVP_ST_BLOCK        1
`define IVP_ST_WINDOW       2

// timing: unlock window in cpu cycles
`define IVP_WINDOW_CYCLES   3'h4
`define IVP_CNT_W           3

// flash word addresses
`define IVP_PC_W            14
`define IVP_FLASH_START     14'h0000
`define IVP_VEC_OFFSET      14'h0002
`define IVP_LAST_VEC_OFFSET 14'h0032
`define IVP_VEC_STRIDE      14'h0002

// boot section starts per boot size code
`define IVP_BOOT_4K         14'h3800
`define IVP_BOOT_2K         14'h3C00
`define IVP_BOOT_1K         14'h3E00
`define IVP_BOOT_512        14'h3F00
`define IVP_SZ_4K           2'h0
`define IVP_SZ_2K           2'h1
`define IVP_SZ_1K           2'h2

`endif

// ==== src/ivp_boot_decode.v ====
// boot section start and vector table base decode
`timescale 1ns/100ps
`default_nettype none
`include "ivp_defines.vh"

module ivp_boot_decode (
  input  wire [1:0]               bootSizeSelect,
  input  wire                     vectorBaseSelect,
  input  wire                     bootResetSelect,
  output wire [`IVP_PC_W-1:0]     bootStart,
  output wire [`IVP_PC_W-1:0]     tableBase,
  output wire [`IVP_PC_W-1:0]     resetAddr
);

  // boot start from size code; fuse decode kept to one lookup
  function [`IVP_PC_W-1:0] bootOf;
    input [1:0] sz;
    begin
      case (sz)
        `IVP_SZ_4K: bootOf = `IVP_BOOT_4K;
        `IVP_SZ_2K: bootOf = `IVP_BOOT_2K;
        `IVP_SZ_1K: bootOf = `IVP_BOOT_1K;
        default:    bootOf = `IVP_BOOT_512;
      endcase
    end
  endfunction

  assign bootStart = bootOf(bootSizeSelect);
  // table base independent of boot reset fuse
  assign tableBase = vectorBaseSelect ? bootStart : `IVP_FLASH_START;
  // fuse is active low: zero means programmed
  assign resetAddr = bootResetSelect ? `IVP_FLASH_START : bootStart;

endmodule
`default_nettype wire

// ==== tb/ivp_vector_place_sva.sv ====
// port assertions for the vector placement block
`timescale 1ns/100ps
`default_nettype none
`include "ivp_defines.vh"
module ivp_vector_place_sva (
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  input wire logic [1:0]  bootSizeSelect,
  input wire logic        bootResetSelect,
  input wire logic        appSideLockBit,
  input wire logic        bootSideLockBit,
  input wire logic [4:0]  vectorNumber,
  input wire logic        globalIntEnable,
  input wire logic        intAllow,
  input wire logic [13:0] tableBase,
  input wire logic [13:0] resetAddr,
  input wire logic [13:0] vectorAddr,
  input wire logic [13:0] storeProgReadyVector
);
  localparam logic [13:0] BS [4] = '{`IVP_BOOT_4K, `IVP_BOOT_2K, `IVP_BOOT_1K, `IVP_BOOT_512};
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // request not yet answered, and the mapped offsets
  wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire logic mapped = wb_adr_i == 4'h0 || wb_adr_i == 4'h4 || wb_adr_i == 4'h8;
  // unlock write answered, then a quiet bus with no lock blocking
  sequence unlockWr;
    wb_ack_o && wb_we_i && wb_adr_i == `IVP_OFF_CTRL && wb_sel_i[0] && wb_dat_i[0];
  endsequence
  sequence quiet;
    (!wb_stb_i && globalIntEnable && !appSideLockBit && !bootSideLockBit) [*4];
  endsequence
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  ack_latency_a: assert property (req && mapped |=> wb_ack_o && !wb_err_o) else $error("no ack");
  unmapped_err_a: assert property (req && !mapped |=> wb_err_o && !wb_ack_o) else $error("no err");
  unlock_hold_a: assert property (unlockWr |-> !intAllow [*5])
    else $error("interrupts open in unlock window");
  hold_ends_a: assert property (unlockWr ##1 quiet |=> intAllow)
    else $error("hold not exactly the window");
  gie_gate_a: assert property (!globalIntEnable |=> !intAllow)
    else $error("interrupts allowed with global enable off");
  base_place_a: assert property ($stable(bootSizeSelect)
    |-> tableBase == 14'h0 || tableBase == BS[bootSizeSelect]) else $error("bad table base");
  spm_vector_a: assert property ($stable(tableBase)
    |-> storeProgReadyVector == tableBase + `IVP_LAST_VEC_OFFSET) else $error("bad last vector");
  vec_addr_a: assert property ($past(rst_b) && $stable(tableBase) && $stable(vectorNumber)
    |-> vectorAddr == tableBase + {vectorNumber, 1'b0}) else $error("bad vector address");
  reset_addr_a: assert property ($past(rst_b) && $stable(bootSizeSelect) && $stable(bootResetSelect)
    |-> resetAddr == (bootResetSelect ? 14'h0 : BS[bootSizeSelect])) else $error("bad reset address");
endmodule
bind ivp_vector_place ivp_vector_place_sva chk (.*);
`default_nettype wire

// ==== tb/ivp_vector_place_bench.sv ====
// self-checking bench for the vector placement block
`timescale 1ns/100ps
`default_nettype none
`include "ivp_defines.vh"
module ivp_vector_place_bench;
  localparam logic [13:0] BS [4] = '{`IVP_BOOT_4K, `IVP_BOOT_2K, `IVP_BOOT_1K, `IVP_BOOT_512};
  logic        clock, rst_b, cyc, stb, we, ret, rsel, aLk, bLk, ack, err, allow, gotErr, gie;
  logic [3:0]  adr;
  logic [1:0]  bsz;
  logic [4:0]  vn;
  logic [13:0] pc, tBase, rAddr, vAddr, spr;
  logic [31:0] wdat, dOut, rdat;
  int          bad_count = 0;
  int          check_count = 0;
  int          cycN = 0;
  ivp_vector_place uut (.clock(clock), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(dOut), .wb_ack_o(ack), .wb_err_o(err),
    .bootSizeSelect(bsz), .bootResetSelect(rsel), .appSideLockBit(aLk), .bootSideLockBit(bLk),
    .instrRetire(ret), .execPc(pc), .vectorNumber(vn), .globalIntEnable(gie), .intAllow(allow),
    .tableBase(tBase), .resetAddr(rAddr), .vectorAddr(vAddr), .storeProgReadyVector(spr));
  // 100 MHz clock
  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  // hang guard, far above the roughly 150 cycles the tests need
  always @(posedge clock) begin
    cycN <= cycN + 1;
    if (cycN == 3000) begin
      bad_count++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  // one classic cycle; outputs read at the edge see pre-edge values
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do @(posedge clock); while (ack !== 1'b1 && err !== 1'b1);
    rdat = dOut;
    gotErr = err;
    {cyc, stb, we} <= 3'b000;
  endtask
  // timed select change; hold must last until a retire
  task automatic move(input logic [31:0] v);
    wb(1, `IVP_OFF_CTRL, 32'h1);
    wb(1, `IVP_OFF_CTRL, v);
    wt(6);
    chk(allow, 0);
    ret <= 1;
    wt(1);
    ret <= 0;
    wt(3);
    chk(allow, 1);
  endtask
  initial begin
    {cyc, stb, we, ret, aLk, bLk, adr, wdat, pc} = '0;
    {rst_b, rsel, bsz, vn} = {1'b0, 1'b1, 2'h1, 5'h1};
    gie = 1'b1;
    wt(20);
    rst_b <= 1;
    wb(0, `IVP_OFF_CTRL, 0);
    chk(rdat, 0);
    chk(tBase, 0);
    chk(spr, 32'h32);
    $display("reset values done");
    // global enable gates the output but is only ever read
    gie <= 1'b0;
    wt(2);
    chk(allow, 32'h0);
    gie <= 1'b1;
    wt(2);
    chk(allow, 32'h1);
    $display("global enable done");
    // unlock alone: short hold, self-clearing bit
    wb(1, `IVP_OFF_CTRL, 32'h1);
    chk(allow, 0);
    // status mid-window: window open and hold on
    wb(0, `IVP_OFF_STATUS, 32'h0);
    chk(rdat, 32'h0000_0005);
    // last held edge, then the first free one
    wt(1);
    chk(allow, 0);
    wt(1);
    chk(allow, 1);
    wb(0, `IVP_OFF_CTRL, 0);
    chk(rdat, 0);
    wb(0, `IVP_OFF_STATUS, 32'h0);
    chk(rdat, 32'h0000_0000);
    // select write with no window, then too late
    wb(1, `IVP_OFF_CTRL, 32'h2);
    wt(2);
    chk(tBase, 0);
    wb(1, `IVP_OFF_CTRL, 32'h1);
    wt(6);
    wb(1, `IVP_OFF_CTRL, 32'h2);
    wt(2);
    chk(tBase, 0);
    $display("unlock window done");
    move(2);
    chk(tBase, 32'h3C00);
    chk(vAddr, 32'h3C02);
    chk(spr, 32'h3C32);
    wb(0, `IVP_OFF_BASE, 0);
    chk(rdat, 32'h3C00);
    wb(0, `IVP_OFF_CTRL, 0);
    chk(rdat, 32'h2);
    // every boot size with boot reset programmed
    rsel <= 0;
    for (int i = 0; i < 4; i++) begin
      bsz <= 2'(i);
      wt(3);
      chk(tBase, BS[i]);
      chk(rAddr, BS[i]);
      chk(vAddr, BS[i] + 14'h2);
    end
    {bsz, rsel} <= {2'h1, 1'b1};
    $display("boot move done");
    // lock bits block the other section
    {aLk, pc} <= {1'b1, 14'h0100};
    wt(3);
    chk(allow, 0);
    wb(0, `IVP_OFF_STATUS, 32'h0);
    chk(rdat, 32'h0000_0002);
    pc <= 14'h3C10;
    wt(3);
    chk(allow, 1);
    aLk <= 0;
    move(0);
    chk(tBase, 0);
    chk(vAddr, 32'h2);
    chk(spr, 32'h32);
    // last vector reached through the vector index too
    vn <= 5'h19;
    wt(2);
    chk(vAddr, 32'h0000_0032);
    vn <= 5'h01;
    bLk <= 1;
    wt(3);
    chk(allow, 0);
    pc <= 14'h0100;
    wt(3);
    chk(allow, 1);
    bLk <= 0;
    // reset in mid-run drops the placement back to flash start
    move(2);
    chk(tBase, 32'h0000_3C00);
    rst_b <= 1'b0;
    wt(2);
    chk(allow, 32'h0);
    chk(tBase, 32'h0000_0000);
    chk(spr, 32'h0000_0032);
    rst_b <= 1'b1;
    wb(0, `IVP_OFF_CTRL, 32'h0);
    chk(rdat, 32'h0000_0000);
    chk(tBase, 32'h0000_0000);
    $display("mid-run reset done");
    wb(0, 4'hC, 0);
    chk(gotErr, 1);
    $display("locks and bus done");
    summarize();
  end
endmodule
`default_nettype wire
